// *** jtag_quick_host.sv ***
// Host that drives quick memory access and flash clock bursts over JTAG pins
`timescale 1ns/1ps
`include "jtq_map.svh"
module jtag_quick_host #(
	parameter logic [7:0]  IR_CTRL      = 8'h01,
	parameter logic [7:0]  IR_DATA16    = 8'h02,
	parameter logic [7:0]  IR_QUICK     = 8'h03,
	parameter logic [7:0]  IR_ADDRCAP   = 8'h04,
	parameter logic [15:0] SETPC_CTRL   = 16'h0001,
	parameter logic [15:0] SETPC_OP     = 16'h0002,
	parameter logic [15:0] HALT_CTRL    = 16'h0003,
	parameter logic [15:0] RELEASE_CTRL = 16'h0004,
	parameter logic [15:0] FLASH_BASE   = 16'h8000,
	parameter logic [16:0] MEM_TOP      = 17'h10000
) (
	// System
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Command
	input  wire logic          cmd_valid,
	input  wire jtq_pkg::cmd_t cmd,
	output logic               cmd_ready,
	output logic               refused,
	output logic               busy,
	output logic [15:0]        ip_model,
	// Write words
	input  wire logic          wr_valid,
	input  wire logic [15:0]   wr_data,
	output logic               wr_ready,
	// Read words
	output logic               rd_valid,
	output logic [15:0]        rd_data,
	input  wire logic          rd_ready,
	// JTAG pins
	output logic               tck,
	output logic               tms,
	output logic               tdi,
	input  wire logic          tdo
);
	import jtq_pkg::*;

	localparam int SHIFT_MIN = 100;
	localparam int SHIFT_MAX = 130;

	seq_state_t  st;
	step_t       cur;
	op_t         op_r;
	logic        nw_r;
	logic [4:0]  idx;
	logic [4:0]  loop_idx;
	logic [15:0] addr_r;
	logic [15:0] remain;
	logic [15:0] words;
	logic [15:0] burst_min;
	logic [15:0] burst_min_r;
	logic        cmd_bad;
	logic        step_go;
	logic        dr_go;
	logic        shift_start;
	logic        shift_done;
	logic [15:0] dr_val;
	logic [7:0]  ir_rev;
	logic [15:0] dr_rev;
	logic [15:0] cap_word;
	logic        tdo_m;
	logic        tdo_s;
	logic        test_derived_cpu_clock;
	logic [8:0]  wait_cnt;
	logic        pc_set;
	logic        quick_on;
	logic [15:0] ip_base;
	logic [15:0] last_lit;
	logic        released;
	logic        sh_busy;
	logic        sh_capf;
	logic [4:0]  sh_i;
	logic [4:0]  sh_len;
	logic [2:0]  sh_div;
	logic [31:0] sh_tms;
	logic [31:0] sh_tdi;
	logic [31:0] cap;
	logic [1:0]  buf_cnt;
	logic [15:0] buf1;
	logic        buf_push;
	logic        buf_pop;
	logic [9:0]  test_derived_cpu_clock_age;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	function automatic step_t mk(step_kind_t k, src_t s, logic [15:0] v);
		step_t r;
		r = '{kind: k, src: s, val: v};
		return r;
	endfunction

	// Step list per operation; the pointer load prefix is shared by both quick kinds
	function automatic step_t step_at(op_t op, logic nw, logic [4:0] i);
		step_t s;
		logic  rd;
		s = mk(K_END, SRC_LIT, 16'h0000);
		rd = (op == OP_READ);
		if (op == OP_BURST) begin
			case (i)
				5'h00: s = mk(K_TH, SRC_LIT, 16'h0000);
				5'h01: s = mk(K_TL, SRC_LIT, 16'h0000);
				5'h02: s = mk(K_NEXT, SRC_LIT, 16'h0000);
				default: s = mk(K_END, SRC_LIT, 16'h0000);
			endcase
		end else if (i <= 5'h08) begin
			case (i)
				5'h00: s = mk(K_IR, SRC_LIT, {8'h00, IR_CTRL});
				5'h01: s = mk(K_DR, SRC_LIT, SETPC_CTRL);
				5'h02: s = mk(K_IR, SRC_LIT, {8'h00, IR_DATA16});
				5'h03: s = mk(K_DR, SRC_LIT, SETPC_OP);
				5'h06: s = mk(K_DR, SRC_ADDR, 16'h0000);
				5'h04, 5'h07: s = mk(K_TH, SRC_LIT, 16'h0000);
				default: s = mk(K_TL, SRC_LIT, 16'h0000);
			endcase
		end else if (!nw) begin
			case (i)
				5'h09: s = mk(K_IR, SRC_LIT, {8'h00, IR_CTRL});
				5'h0a: s = mk(K_DR, SRC_LIT, HALT_CTRL);
				5'h0b: s = mk(K_TL, SRC_LIT, 16'h0000);
				5'h0c: s = mk(K_IR, SRC_LIT, {8'h00, IR_CTRL});
				5'h0d: s = mk(K_DR, SRC_LIT, rd ? `RW_READ_OLD : `RW_WRITE_OLD);
				5'h0e: s = mk(K_IR, SRC_LIT, {8'h00, IR_QUICK});
				5'h0f: s = rd ? mk(K_TH, SRC_LIT, 16'h0000) : mk(K_DR, SRC_DATA, 16'h0000);
				5'h10: s = rd ? mk(K_DR, SRC_CAP, 16'h0000) : mk(K_TH, SRC_LIT, 16'h0000);
				5'h11: s = mk(K_TL, SRC_LIT, 16'h0000);
				5'h12: s = mk(K_NEXT, SRC_LIT, 16'h0000);
				5'h13: s = mk(K_IR, SRC_LIT, {8'h00, IR_CTRL});
				5'h14: s = mk(K_DR, SRC_LIT, RELEASE_CTRL);
				default: s = mk(K_END, SRC_LIT, 16'h0000);
			endcase
		end else begin
			case (i)
				5'h09: s = mk(K_TH, SRC_LIT, 16'h0000);
				5'h0a: s = mk(K_IR, SRC_LIT, {8'h00, IR_CTRL});
				5'h0b: s = mk(K_DR, SRC_LIT, `RW_READ_NEW);
				5'h0c: s = mk(K_IR, SRC_LIT, {8'h00, IR_ADDRCAP});
				5'h0d: s = mk(K_IR, SRC_LIT, {8'h00, IR_QUICK});
				5'h0e: s = mk(K_TH, SRC_LIT, 16'h0000);
				5'h0f: s = mk(K_TL, SRC_LIT, 16'h0000);
				5'h10: s = mk(K_DR, SRC_CAP, 16'h0000);
				5'h11: s = mk(K_NEXT, SRC_LIT, 16'h0000);
				default: s = mk(K_END, SRC_LIT, 16'h0000);
			endcase
		end
		return s;
	endfunction

	// Command screening; bad requests are consumed and flagged, never run
	assign cmd_bad = (cmd.op == OP_WRITE && (cmd.newest || cmd.addr >= FLASH_BASE))
		|| (cmd.op == OP_READ && cmd.newest
		&& ({2'b00, cmd.addr} + {1'b0, cmd.count, 1'b0} > {1'b0, MEM_TOP}))
		|| (cmd.op != OP_BURST && cmd.count == 16'h0000)
		|| (cmd.op == OP_BURST && cmd.kind != BK_WORD && cmd.kind != BK_SEGMENT
		&& cmd.kind != BK_MASS);

	// Cycle floors only valid with timing control low byte at FTC_LOW_BYTE
	always_comb begin
		case (cmd.kind)
			BK_SEGMENT: burst_min = `CYC_SEGMENT;
			BK_MASS: burst_min = `CYC_MASS;
			default: burst_min = `CYC_WORD;
		endcase
	end

	assign cur = step_at(op_r, nw_r, idx);
	assign dr_go = (cur.src != SRC_DATA || wr_valid) && (cur.src != SRC_CAP || buf_cnt != 2'h2);
	assign step_go = (st == S_STEP) && (cur.kind != K_DR || dr_go);
	assign shift_start = step_go && (cur.kind == K_IR || cur.kind == K_DR);
	assign wr_ready = (st == S_STEP) && cur.kind == K_DR && cur.src == SRC_DATA;
	assign cmd_ready = (st == S_IDLE);
	assign busy = (st != S_IDLE);

	// Sequencer walks the step list; a stalled word only holds the step, not the link
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_IDLE;
			idx <= 5'h00;
			loop_idx <= 5'h00;
			op_r <= OP_READ;
			nw_r <= 1'b0;
			addr_r <= 16'h0000;
			remain <= 16'h0000;
			words <= 16'h0000;
			burst_min_r <= 16'h0000;
			refused <= 1'b0;
		end else begin
			refused <= 1'b0;
			case (st)
				S_IDLE: if (cmd_valid) begin
					if (cmd_bad) begin
						refused <= 1'b1;
					end else begin
						st <= S_STEP;
						idx <= 5'h00;
						op_r <= cmd.op;
						nw_r <= cmd.newest;
						words <= 16'h0000;
						burst_min_r <= burst_min;
						addr_r <= cmd.newest ? cmd.addr : cmd.addr - `PC_BACKOFF;
						if (cmd.op == OP_BURST) begin
							remain <= (cmd.count > burst_min) ? cmd.count : burst_min;
							loop_idx <= 5'h00;
						end else begin
							remain <= cmd.count;
							loop_idx <= cmd.newest ? 5'h0e : 5'h0f;
						end
					end
				end
				S_STEP: begin
					case (cur.kind)
						K_IR: st <= S_SHIFT;
						K_DR: if (dr_go) st <= S_SHIFT;
						K_TH, K_TL: st <= S_TEST_DERIVED_CPU_CLOCK;
						K_NEXT: begin
							words <= words + 16'h0001;
							if (remain > 16'h0001) begin
								remain <= remain - 16'h0001;
							end
						end
						default: st <= S_IDLE;
					endcase
					if (cur.kind == K_NEXT && remain > 16'h0001) begin
						idx <= loop_idx;
					end else if (step_go) begin
						idx <= idx + 5'h01;
					end
				end
				S_SHIFT: if (shift_done) st <= S_STEP;
				S_TEST_DERIVED_CPU_CLOCK: if (wait_cnt == 9'h000) st <= S_STEP;
				default: st <= S_IDLE;
			endcase
		end
	end

	// Test-derived clock sits on the data pin in idle; same rate whatever the wire mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			test_derived_cpu_clock <= 1'b0;
			wait_cnt <= 9'h000;
		end else if (st == S_STEP && (cur.kind == K_TH || cur.kind == K_TL)) begin
			test_derived_cpu_clock <= (cur.kind == K_TH);
			wait_cnt <= 9'(`TEST_DERIVED_CPU_CLOCK_HALF_CYC - 1);
		end else if (wait_cnt != 9'h000) begin
			wait_cnt <= wait_cnt - 9'h001;
		end
	end

	// Host copy of the device pointer, used to check the auto increment
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ip_model <= 16'h0000;
			ip_base <= 16'h0000;
			pc_set <= 1'b0;
			quick_on <= 1'b0;
			last_lit <= 16'h0000;
			released <= 1'b0;
		end else if (st == S_IDLE) begin
			pc_set <= 1'b0;
			quick_on <= 1'b0;
			released <= 1'b0;
		end else if (step_go) begin
			if (cur.kind == K_DR && cur.src == SRC_ADDR) begin
				ip_model <= addr_r;
				pc_set <= 1'b1;
			end
			if (cur.kind == K_DR && cur.src == SRC_LIT) begin
				last_lit <= cur.val;
				if (cur.val == RELEASE_CTRL && idx == 5'h14) released <= 1'b1;
			end
			if (cur.kind == K_IR && cur.val[7:0] == IR_QUICK) begin
				quick_on <= 1'b1;
				ip_base <= ip_model;
			end
			if (cur.kind == K_TL && quick_on) ip_model <= ip_model + `PC_STEP;
		end
	end

	assign ir_rev = {<<{cur.val[7:0]}};
	assign dr_rev = {<<{dr_val}};
	assign cap_word = {<<{cap[`DR_FIRST +: 16]}};

	always_comb begin
		case (cur.src)
			SRC_ADDR: dr_val = addr_r;
			SRC_DATA: dr_val = wr_data;
			SRC_LIT: dr_val = cur.val;
			default: dr_val = 16'h0000;
		endcase
	end

	// TDO crosses in from the pin through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tdo_m <= 1'b0;
			tdo_s <= 1'b0;
		end else begin
			tdo_m <= tdo;
			tdo_s <= tdo_m;
		end
	end

	assign shift_done = sh_busy && tck && sh_div == `TCK_HALF_CYC - 3'h1 && sh_i == sh_len;

	// TAP frame engine: from idle, scan MSB first, back to idle; TCK from a divider
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_busy <= 1'b0;
			sh_capf <= 1'b0;
			sh_i <= 5'h00;
			sh_len <= 5'h00;
			sh_div <= 3'h0;
			sh_tms <= 32'h0000_0000;
			sh_tdi <= 32'h0000_0000;
			cap <= 32'h0000_0000;
			tck <= 1'b0;
			tms <= 1'b0;
			tdi <= 1'b0;
		end else if (shift_start) begin
			sh_busy <= 1'b1;
			sh_capf <= (cur.kind == K_DR && cur.src == SRC_CAP);
			sh_i <= 5'h00;
			sh_div <= 3'h0;
			sh_len <= (cur.kind == K_IR) ? `IR_LAST : `DR_LAST;
			sh_tms <= (cur.kind == K_IR) ? `IR_TMS : `DR_TMS;
			sh_tdi <= (cur.kind == K_IR) ? ({24'h000000, ir_rev} << `IR_FIRST)
				: ({16'h0000, dr_rev} << `DR_FIRST);
			tms <= 1'b1;
			tdi <= 1'b0;
		end else if (sh_busy) begin
			if (sh_div == `TCK_HALF_CYC - 3'h1) begin
				sh_div <= 3'h0;
				tck <= ~tck;
				if (!tck) begin
					cap[sh_i] <= tdo_s;
				end else if (sh_i == sh_len) begin
					sh_busy <= 1'b0;
					tms <= 1'b0;
					tdi <= test_derived_cpu_clock; // No stray test clock edge as idle resumes
				end else begin
					sh_i <= sh_i + 5'h01;
					tms <= sh_tms[sh_i + 5'h01];
					tdi <= sh_tdi[sh_i + 5'h01];
				end
			end else begin
				sh_div <= sh_div + 3'h1;
			end
		end else begin
			tms <= 1'b0;
			tdi <= test_derived_cpu_clock;
		end
	end

	assign buf_push = shift_done && sh_capf;
	assign buf_pop = rd_valid && rd_ready;
	assign rd_valid = (buf_cnt != 2'h0);

	// Two-entry read buffer so a stalled reader loses no word
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			buf_cnt <= 2'h0;
			rd_data <= 16'h0000;
			buf1 <= 16'h0000;
		end else begin
			case ({buf_push, buf_pop})
				2'b10: begin
					if (buf_cnt == 2'h0) rd_data <= cap_word;
					else buf1 <= cap_word;
					buf_cnt <= buf_cnt + 2'h1;
				end
				2'b01: begin
					rd_data <= buf1;
					buf_cnt <= buf_cnt - 2'h1;
				end
				2'b11: begin
					if (buf_cnt == 2'h1) begin
						rd_data <= cap_word;
					end else begin
						rd_data <= buf1;
						buf1 <= cap_word;
					end
				end
				default: buf_cnt <= buf_cnt;
			endcase
		end
	end

	// Cycles since the last test clock edge, for the rate check
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) test_derived_cpu_clock_age <= 10'h3ff;
		else if (st == S_STEP && (cur.kind == K_TH || cur.kind == K_TL)) test_derived_cpu_clock_age <= 10'h000;
		else if (test_derived_cpu_clock_age != 10'h3ff) test_derived_cpu_clock_age <= test_derived_cpu_clock_age + 10'h001;
	end

	sequence s_issue_cap;
		step_go && cur.kind == K_IR && cur.val[7:0] == IR_ADDRCAP;
	endsequence
	sequence s_issue_quick;
		step_go && cur.kind == K_IR && cur.val[7:0] == IR_QUICK;
	endsequence

	a_test_derived_cpu_clock_half_period: assert property (
		$changed(test_derived_cpu_clock) |-> $past(test_derived_cpu_clock_age) >= 10'(`TEST_DERIVED_CPU_CLOCK_HALF_CYC - 1))
		else $error("test clock half period too short");
	a_pc_before_quick: assert property (
		$rose(quick_on) |-> pc_set && $past(pc_set))
		else $error("quick instruction before pointer load");
	a_write_clock_low: assert property (
		(step_go && cur.kind == K_DR && cur.src == SRC_DATA) |-> !test_derived_cpu_clock)
		else $error("write data shifted with clock high");
	a_read_clock_high: assert property (
		(sh_capf && sh_busy && !nw_r) |-> test_derived_cpu_clock)
		else $error("read capture with clock low");
	a_rw_control_word: assert property (
		$rose(quick_on) |-> last_lit == (nw_r ? `RW_READ_NEW
			: (op_r == OP_READ ? `RW_READ_OLD : `RW_WRITE_OLD)))
		else $error("wrong control word before quick instruction");
	a_capture_then_quick: assert property (
		s_issue_cap |-> ##[SHIFT_MIN:SHIFT_MAX] s_issue_quick)
		else $error("quick instruction does not follow address capture");
	a_quick_write_screen: assert property (
		(cmd_valid && cmd_ready && cmd.op == OP_WRITE
			&& (cmd.newest || cmd.addr >= FLASH_BASE)) |=> refused && st == S_IDLE)
		else $error("forbidden quick write was started");
	a_release_at_end: assert property (
		(st == S_STEP && cur.kind == K_END && op_r != OP_BURST && !nw_r) |-> released)
		else $error("older quick sequence ended without release");
	a_burst_minimum: assert property (
		(st == S_STEP && cur.kind == K_END && op_r == OP_BURST) |-> words >= burst_min_r)
		else $error("flash burst shorter than minimum");
	a_pointer_advance: assert property (
		(st == S_STEP && cur.kind == K_END && quick_on) |-> ip_model == ip_base + {words[14:0], 1'b0})
		else $error("pointer did not advance by two per word");
endmodule // jtag_quick_host

// *** jtq_map.svh ***
// Constants for the quick memory access host: timing, frames and control words
`ifndef JTQ_MAP_SVH
`define JTQ_MAP_SVH
`define SYS_FREQ_KHZ 250000
`define TEST_DERIVED_CPU_CLOCK_FREQ_KHZ 350
`define TEST_DERIVED_CPU_CLOCK_TOL_KHZ 100
`define TEST_DERIVED_CPU_CLOCK_HALF_CYC (`SYS_FREQ_KHZ / (2 * `TEST_DERIVED_CPU_CLOCK_FREQ_KHZ))
`define TCK_HALF_CYC 3'h4
`define CYC_SEGMENT 16'h12d4
`define CYC_MASS 16'h2968
`define CYC_WORD 16'h0023
`define FTC_LOW_BYTE 8'h40
`define RW_READ_OLD 16'h2409
`define RW_WRITE_OLD 16'h2408
`define RW_READ_NEW 16'h0501
`define PC_BACKOFF 16'h0004
`define PC_STEP 16'h0002
`define IR_TMS 32'h0000_1803
`define DR_TMS 32'h000c_0001
`define IR_FIRST 4
`define DR_FIRST 3
`define IR_LAST 5'h0d
`define DR_LAST 5'h14
`endif

// *** jtq_pkg.sv ***
// Types shared by the quick memory access host
package jtq_pkg;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_BURST} op_t;
	typedef enum logic [1:0] {BK_WORD, BK_SEGMENT, BK_MASS} burst_t;
	typedef struct packed {
		op_t         op;
		logic        newest;
		burst_t      kind;
		logic [15:0] addr;
		logic [15:0] count;
	} cmd_t;
	typedef enum logic [2:0] {K_IR, K_DR, K_TH, K_TL, K_NEXT, K_END} step_kind_t;
	typedef enum logic [1:0] {SRC_LIT, SRC_ADDR, SRC_DATA, SRC_CAP} src_t;
	typedef struct packed {
		step_kind_t  kind;
		src_t        src;
		logic [15:0] val;
	} step_t;
	typedef enum {S_IDLE, S_STEP, S_SHIFT, S_TEST_DERIVED_CPU_CLOCK} seq_state_t;
endpackage

// *** jtq_dev_model.sv ***
// Behavioural device side of the test port: frames, quick access pipeline, word memory
`timescale 1ns/1ps
`include "jtq_map.svh"
module jtq_dev_model #(
	parameter logic [7:0]  IR_CTRL      = 8'h01,
	parameter logic [7:0]  IR_DATA16    = 8'h02,
	parameter logic [7:0]  IR_QUICK     = 8'h03,
	parameter logic [15:0] SETPC_OP     = 16'h0002,
	parameter logic [15:0] HALT_CTRL    = 16'h0003,
	parameter logic [15:0] RELEASE_CTRL = 16'h0004
) (
	// System
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Test port
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	output logic      tdo
);
	logic [15:0] mem [0:32767];
	logic [15:0] ctrl, ip, last_data, sr, out_sr, memory_data_bus;
	logic [7:0]  ir;
	logic [4:0]  pos;
	logic        is_ir, tck_q, test_derived_cpu_clock, gap, released;
	int          n_rise, n_capt, n_store, n_frame, since, min_iv, max_iv;
	wire         newest = (ctrl == `RW_READ_NEW);
	wire         quick  = (ir == IR_QUICK);
	// Newest core points one word ahead, older ones sit four bytes behind
	wire [15:0]  raddr  = newest ? ip - 16'h0002 : ip + 16'h0004;
	wire         idle   = !tms && pos == 5'd0 && !tck;

	// Frames on tck, test clock on tdi between frames; clk_sys sampling avoids races
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{ctrl, ip, last_data, sr, out_sr, memory_data_bus, ir, pos} <= '0;
			{is_ir, tck_q, test_derived_cpu_clock, gap, released, tdo} <= '0;
			{n_rise, n_capt, n_store, n_frame, since, max_iv} <= '0;
			min_iv <= 32'h7fff_ffff;
		end else begin
			tck_q <= tck;
			since <= since + 1;
			if (tck && !tck_q) begin
				gap <= 1'b1;
				pos <= pos + 5'd1;
				if (pos == 5'd1)
					is_ir <= tms;
				if (pos >= 5'd3 && pos <= (is_ir ? 5'd11 : 5'd18))
					sr <= {sr[14:0], tdi};
				if (pos == 5'd2 && !is_ir && quick && ctrl[0]) begin
					out_sr <= mem[raddr[15:1]];
					n_capt <= n_capt + 1;
				end
				if (pos == (is_ir ? 5'd13 : 5'd20)) begin
					pos <= 5'd0;
					n_frame <= n_frame + 1;
					if (is_ir)
						ir <= sr[7:0];
					else if (ir == IR_CTRL) begin
						ctrl <= sr;
						released <= (sr == RELEASE_CTRL) ? 1'b1 : (sr == HALT_CTRL) ? 1'b0 : released;
					end else if (ir == IR_DATA16) begin
						last_data <= sr;
						if (last_data == SETPC_OP)
							ip <= sr;
					end else if (quick)
						memory_data_bus <= sr;
				end
			end
			// A released line shows the inverse of its last value, not a steady guess
			if (!tck && tck_q)
				tdo <= (!is_ir && pos >= 5'd3 && pos <= 5'd18) ? out_sr[5'd18 - pos] : ~tdo;
			if (idle && tdi != test_derived_cpu_clock) begin
				test_derived_cpu_clock <= tdi;
				if (tdi) begin
					n_rise <= n_rise + 1;
					since <= 0;
					gap <= 1'b0;
					if (!gap && n_rise > 0) begin
						min_iv <= (since < min_iv) ? since : min_iv;
						max_iv <= (since > max_iv) ? since : max_iv;
					end
					if (quick && !ctrl[0] && !newest) begin
						mem[raddr[15:1]] <= memory_data_bus;
						n_store <= n_store + 1;
					end
				end else if (quick)
					ip <= ip + `PC_STEP;
			end
		end
	end
endmodule // jtq_dev_model

// *** tb_jtag_quick_mem_flash_timing.sv ***
// Self-checking bench for the quick memory access host against the device model
`timescale 1ns/1ps
`include "jtq_map.svh"
module tb_jtag_quick_mem_flash_timing;
	import jtq_pkg::*;
	logic        clk_sys, rst_n, cmd_valid, cmd_ready, refused, busy;
	logic        wr_valid, wr_ready, rd_valid, rd_ready, tck, tms, tdi, tdo;
	logic [15:0] ip_model, wr_data, rd_data;
	cmd_t        cmd;
	int          fail_count, n_tests;

	jtag_quick_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .refused(refused), .busy(busy), .ip_model(ip_model),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_ready(rd_ready), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	jtq_dev_model model (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo));

	// 250 MHz system clock
	initial clk_sys = 1'b0;
	always #2 clk_sys = ~clk_sys;

	function automatic logic [15:0] pat(input logic [15:0] a);
		return {a[7:0] ^ 8'h5a, a[15:8] ^ 8'ha5};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// A wait that runs out ends the run at once
	task automatic timeout(input string what);
		fail_count++;
		$display("MISMATCH %s expected done seen timeout", what);
		stop_test();
	endtask

	task automatic issue(input cmd_t c, input logic bad);
		int i;
		i = 0;
		@(posedge clk_sys);
		cmd <= c;
		cmd_valid <= 1'b1;
		do begin @(posedge clk_sys); i++; end while (!cmd_ready && i < 100);
		if (!cmd_ready)
			timeout("cmd_ready");
		cmd_valid <= 1'b0;
		@(posedge clk_sys);
		check("refused", bad, refused);
		check("busy", !bad, busy);
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 60000 && busy; i++)
			@(posedge clk_sys);
		if (busy)
			timeout("busy");
	endtask

	// Bad commands leave the link silent
	task automatic s_refused();
		cmd_t bad [5];
		int   f0, k;
		bad = '{'{OP_WRITE, 1'b1, BK_WORD, 16'h0200, 16'h0001},
			'{OP_WRITE, 1'b0, BK_WORD, 16'h8000, 16'h0001},
			'{OP_READ, 1'b1, BK_WORD, 16'hfffc, 16'h0003},
			'{OP_READ, 1'b0, BK_WORD, 16'h0200, 16'h0000},
			'{OP_BURST, 1'b0, burst_t'(2'h3), 16'h0000, 16'h0001}};
		f0 = model.n_frame;
		for (k = 0; k < 5; k++)
			issue(bad[k], 1'b1);
		check("frames", f0, model.n_frame);
	endtask

	// Write data stays offered across words and drops after the last one
	task automatic s_quick_write(input logic [15:0] a, input int n);
		int i, k, s0;
		s0 = model.n_store;
		issue('{OP_WRITE, 1'b0, BK_WORD, a, 16'(n)}, 1'b0);
		wr_data <= pat(a);
		wr_valid <= 1'b1;
		for (k = 0; k < n; k++) begin
			i = 0;
			do begin @(posedge clk_sys); i++; end while (!wr_ready && i < 9000);
			if (!wr_ready)
				timeout("wr_ready");
			wr_data <= pat(a + 16'(2 * (k + 1)));
			if (k == n - 1)
				wr_valid <= 1'b0;
		end
		wait_idle();
		check("stores", s0 + n, model.n_store);
		check("ip", 16'(a - 16'h0004 + 16'(2 * n)), model.ip);
		check("ip_model", 16'(a - 16'h0004 + 16'(2 * n)), ip_model);
		check("released", 1'b1, model.released);
	endtask

	// With stall set the consumer holds off until two words wait in the buffer
	task automatic s_quick_read(input logic [15:0] a, input int n, input logic nw,
		input logic stall);
		int          i, k, c0;
		logic [15:0] ip_end;
		c0 = model.n_capt;
		ip_end = nw ? 16'(a + 16'(2 * n)) : 16'(a - 16'h0004 + 16'(2 * n));
		issue('{OP_READ, nw, BK_WORD, a, 16'(n)}, 1'b0);
		if (stall) begin
			for (i = 0; i < 30000 && model.n_capt < c0 + 2; i++)
				@(posedge clk_sys);
			repeat (3000) @(posedge clk_sys);
			check("held captures", c0 + 2, model.n_capt);
			check("rd_valid held", 1'b1, rd_valid);
		end
		rd_ready <= 1'b1;
		for (k = 0; k < n; k++) begin
			i = 0;
			do begin @(posedge clk_sys); i++; end while (!rd_valid && i < 9000);
			if (!rd_valid)
				timeout("rd_valid");
			check("read word", pat(a + 16'(2 * k)), rd_data);
			if (k == n - 1)
				rd_ready <= 1'b0;
		end
		wait_idle();
		check("ip", ip_end, model.ip);
		check("ip_model", ip_end, ip_model);
	endtask

	// Short word burst is stretched to the minimum count at the flash clock rate
	task automatic s_burst();
		int r0;
		r0 = model.n_rise;
		issue('{OP_BURST, 1'b0, BK_WORD, 16'h0000, 16'h0003}, 1'b0);
		wait_idle();
		check("burst clocks", `CYC_WORD, model.n_rise - r0);
		check("period window", 1'b1,
			model.min_iv >= `SYS_FREQ_KHZ / (`TEST_DERIVED_CPU_CLOCK_FREQ_KHZ + `TEST_DERIVED_CPU_CLOCK_TOL_KHZ) &&
			model.max_iv <= `SYS_FREQ_KHZ / (`TEST_DERIVED_CPU_CLOCK_FREQ_KHZ - `TEST_DERIVED_CPU_CLOCK_TOL_KHZ));
	endtask

	// Main sequence
	initial begin
		{cmd_valid, wr_valid, rd_ready, rst_n, cmd, wr_data} = '0;
		fail_count = 0;
		n_tests = 0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		s_refused();
		s_quick_write(16'h0200, 4);
		s_quick_read(16'h0200, 3, 1'b0, 1'b1);
		s_quick_read(16'h0202, 2, 1'b1, 1'b0);
		s_burst();
		stop_test();
	end
endmodule // tb_jtag_quick_mem_flash_timing
